// File: pkg/prc_pkg.sv
package prc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int BYTE_N = 4;
    localparam int WORD_LSB = 2;

    ////////////////////////////////////////////////////////////////////////
    // register map
    localparam logic [7:0] RST_REG_OFFSET = 8'h10;
    localparam logic [7:0] CLK_REG_OFFSET = 8'h14;
    localparam logic [31:0] RST_REG_RESET = 32'h0000_0000;
    localparam logic [31:0] CLK_REG_RESET = 32'h0000_0014;
    // only documented bits store; reserved bits read as zero
    localparam logic [31:0] RST_REG_MASK = 32'h1062_4912;
    localparam logic [31:0] CLK_REG_MASK = 32'h004e_0055;

    ////////////////////////////////////////////////////////////////////////
    // reset register fields
    localparam int BIT_POWER_UNIT = 28;
    localparam int BIT_SECOND_I2C = 22;
    localparam int BIT_FIRST_I2C = 21;
    localparam int BIT_SECOND_SERIAL = 17;
    localparam int BIT_SECOND_SPI = 14;
    localparam int BIT_WATCHDOG = 11;
    localparam int BIT_TIMER_13 = 8;
    localparam int BIT_TIMER_5 = 4;
    localparam int BIT_TIMER_2 = 1;

    ////////////////////////////////////////////////////////////////////////
    // clock enable register fields
    localparam int BIT_PORT_F = 22;
    localparam int BIT_PORT_C = 19;
    localparam int BIT_PORT_B = 18;
    localparam int BIT_PORT_A = 17;
    localparam int BIT_CHECKSUM = 6;
    localparam int BIT_FLASH_KEEP = 4;
    localparam int BIT_RAM_KEEP = 2;
    localparam int BIT_DMA = 0;

    ////////////////////////////////////////////////////////////////////////
    // gated clock outputs
    localparam int GATE_N = 8;
    localparam int GATE_PORT_A = 0;
    localparam int GATE_PORT_B = 1;
    localparam int GATE_PORT_C = 2;
    localparam int GATE_PORT_F = 3;
    localparam int GATE_CHECKSUM = 4;
    localparam int GATE_DMA = 5;
    localparam int GATE_FLASH = 6;
    localparam int GATE_RAM = 7;
    localparam logic [7:0] GATE_RESET = 8'hc0;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic powerUnit;
        logic secondI2c;
        logic firstI2c;
        logic secondSerialPort;
        logic secondSpi;
        logic windowWatchdog;
        logic timer13;
        logic timer5;
        logic timer2;
    } prc_reset_req_t;

    typedef enum logic [0:0] {
        WR_IDLE = 1'h0,
        WR_RESP = 1'h1
    } prc_wr_state_t;

endpackage : prc_pkg

// File: tb/periph_reset_and_clock_gate_tb.sv
`timescale 1ns/1ps
module periph_reset_and_clock_gate_tb;
    import prc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic ref_clk = 1'h0;
    logic resetn = 1'h0;
    logic sleepMode = 1'h0;
    logic [ADDR_W-1:0] awAddr = 8'h00;
    logic awValid = 1'h0;
    logic awReady;
    logic [DATA_W-1:0] wData = 32'h0000_0000;
    logic [BYTE_N-1:0] wStrb = 4'h0;
    logic wValid = 1'h0;
    logic wReady;
    logic [1:0] bResp;
    logic bValid;
    logic bReady = 1'h0;
    logic [ADDR_W-1:0] arAddr = 8'h00;
    logic arValid = 1'h0;
    logic arReady;
    logic [DATA_W-1:0] rData;
    logic [1:0] rResp;
    logic rValid;
    logic rReady = 1'h0;
    prc_reset_req_t resetReq;
    logic [GATE_N-1:0] gatedClks;
    int errCount = 0;
    int numChecks = 0;
    logic [31:0] seed = 32'h0000_005f;
    logic [31:0] rstModel = 32'h0000_0000;
    logic [31:0] clkModel = 32'h0000_0014;
    logic [1:0] bQ[$];
    logic [33:0] rQ[$];
    logic [33:0] rNote;
    int rstBits[9] = '{BIT_POWER_UNIT, BIT_SECOND_I2C, BIT_FIRST_I2C,
        BIT_SECOND_SERIAL, BIT_SECOND_SPI, BIT_WATCHDOG, BIT_TIMER_13,
        BIT_TIMER_5, BIT_TIMER_2};
    int clkBits[8] = '{BIT_PORT_F, BIT_PORT_C, BIT_PORT_B, BIT_PORT_A,
        BIT_CHECKSUM, BIT_FLASH_KEEP, BIT_RAM_KEEP,
        BIT_DMA};

    always #25 ref_clk = ~ref_clk;

    prc_top uut (
        .ref_clk(ref_clk), .resetn(resetn), .sleepMode(sleepMode),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
        .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
        .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
        .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
        .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
        .s_axi_rvalid(rValid), .s_axi_rready(rReady),
        .resetReq(resetReq), .gatedClks(gatedClks)
    );

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] next_rand(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        y = y ^ (y << 5);
        return y;
    endfunction : next_rand

    // only addressed bytes change, reserved bits never stick
    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] d, input logic [3:0] s, input logic [31:0] m);
        logic [31:0] r;
        r = old;
        for (int k = 0; k < 4; k++)
            if (s[k]) r[8*k+:8] = d[8*k+:8] & m[8*k+:8];
        return r;
    endfunction : merge

    function automatic logic [7:0] gate_exp(input logic [31:0] c,
        input logic s);
        logic [7:0] g;
        g[GATE_PORT_A] = c[BIT_PORT_A];
        g[GATE_PORT_B] = c[BIT_PORT_B];
        g[GATE_PORT_C] = c[BIT_PORT_C];
        g[GATE_PORT_F] = c[BIT_PORT_F];
        g[GATE_CHECKSUM] = c[BIT_CHECKSUM];
        g[GATE_DMA] = c[BIT_DMA];
        g[GATE_FLASH] = !s | c[BIT_FLASH_KEEP];
        g[GATE_RAM] = !s | c[BIT_RAM_KEEP];
        return g;
    endfunction : gate_exp

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        numChecks++;
        if (seen !== exp)
        begin
            errCount++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic give_verdict();
        if (errCount == 0 && numChecks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : give_verdict

    ////////////////////////////////////////////////////////////////////////
    task automatic axi_write(input logic [7:0] addr, input logic [31:0] data,
        input logic [3:0] strb);
        logic awPend;
        logic wPend;
        awPend = 1'h1;
        wPend = 1'h1;
        @(posedge ref_clk);
        awAddr <= addr;
        awValid <= 1'h1;
        wData <= data;
        wStrb <= strb;
        wValid <= 1'h1;
        bReady <= 1'h1;
        if (addr == RST_REG_OFFSET)
            rstModel = merge(rstModel, data, strb, RST_REG_MASK);
        if (addr == CLK_REG_OFFSET)
            clkModel = merge(clkModel, data, strb, CLK_REG_MASK);
        if (addr == RST_REG_OFFSET || addr == CLK_REG_OFFSET)
            bQ.push_back(RESP_OKAY);
        else
            bQ.push_back(RESP_SLVERR);
        do
        begin
            @(posedge ref_clk);
            if (awPend && awReady) awValid <= 1'h0;
            if (awPend && awReady) awPend = 1'h0;
            if (wPend && wReady) wValid <= 1'h0;
            if (wPend && wReady) wPend = 1'h0;
        end while (!bValid);
        bReady <= 1'h0;
    endtask : axi_write

    task automatic axi_read(input logic [7:0] addr);
        @(posedge ref_clk);
        arAddr <= addr;
        arValid <= 1'h1;
        rReady <= 1'h1;
        if (addr == RST_REG_OFFSET)
            rQ.push_back({RESP_OKAY, rstModel});
        else if (addr == CLK_REG_OFFSET)
            rQ.push_back({RESP_OKAY, clkModel});
        else
            rQ.push_back({RESP_SLVERR, 32'h0000_0000});
        do
        begin
            @(posedge ref_clk);
            if (arValid && arReady) arValid <= 1'h0;
        end while (!rValid);
        rReady <= 1'h0;
    endtask : axi_read

    // full high phase and dead low phase, so no clipped pulse
    task automatic check_outputs();
        @(posedge ref_clk);
        #2;
        check({23'h0, resetReq}, {23'h0, rstModel[BIT_POWER_UNIT],
            rstModel[BIT_SECOND_I2C], rstModel[BIT_FIRST_I2C],
            rstModel[BIT_SECOND_SERIAL], rstModel[BIT_SECOND_SPI],
            rstModel[BIT_WATCHDOG], rstModel[BIT_TIMER_13],
            rstModel[BIT_TIMER_5], rstModel[BIT_TIMER_2]});
        check({24'h0, gatedClks}, {24'h0, gate_exp(clkModel, sleepMode)});
        #20;
        check({24'h0, gatedClks}, {24'h0, gate_exp(clkModel, sleepMode)});
        #5;
        check({24'h0, gatedClks}, 32'h0000_0000);
    endtask : check_outputs

    ////////////////////////////////////////////////////////////////////////
    // result watcher: oldest note against each answer
    always @(posedge ref_clk)
    begin
        if (resetn && bValid && bReady && bQ.size() > 0)
            check({30'h0, bResp}, {30'h0, bQ.pop_front()});
        if (resetn && rValid && rReady && rQ.size() > 0)
        begin
            rNote = rQ.pop_front();
            check(rData, rNote[31:0]);
            check({30'h0, rResp}, {30'h0, rNote[33:32]});
        end
    end

    initial
    begin
        #2_000_000;
        errCount++;
        give_verdict();
    end

    initial
    begin
        logic [31:0] data;
        logic [7:0] addr;
        repeat (4) @(posedge ref_clk);
        resetn <= 1'h1;
        axi_read(RST_REG_OFFSET);
        axi_read(CLK_REG_OFFSET);
        check_outputs();
        foreach (rstBits[i])
        begin
            axi_write(RST_REG_OFFSET, 32'h1 << rstBits[i], 4'hf);
            check_outputs();
            axi_read(RST_REG_OFFSET);
        end
        for (int s = 0; s < 2; s++)
        begin
            sleepMode <= s[0];
            foreach (clkBits[i])
            begin
                axi_write(CLK_REG_OFFSET, 32'h1 << clkBits[i], 4'hf);
                check_outputs();
                axi_read(CLK_REG_OFFSET);
            end
        end
        // random data under every strobe pattern, both registers
        for (int i = 0; i < 32; i++)
        begin
            seed = next_rand(seed);
            addr = seed[20] ? CLK_REG_OFFSET : RST_REG_OFFSET;
            data = seed & (seed[20] ? CLK_REG_MASK : RST_REG_MASK);
            // stimulus moves only right after a rising edge
            @(posedge ref_clk);
            sleepMode <= seed[25];
            axi_write(addr, data, i[3:0]);
            axi_read(addr);
            check_outputs();
        end
        axi_write(8'h20, 32'hffff_ffff, 4'hf);
        axi_read(8'h20);
        repeat (20) @(posedge ref_clk);
        axi_read(RST_REG_OFFSET);
        axi_read(CLK_REG_OFFSET);
        // second reset in mid-run
        @(posedge ref_clk);
        resetn <= 1'h0;
        repeat (2) @(posedge ref_clk);
        resetn <= 1'h1;
        rstModel = 32'h0000_0000;
        clkModel = 32'h0000_0014;
        axi_read(RST_REG_OFFSET);
        axi_read(CLK_REG_OFFSET);
        check_outputs();
        give_verdict();
    end

endmodule : periph_reset_and_clock_gate_tb

// File: verilog/prc_byte_reg.sv
`timescale 1ns/1ps
module prc_byte_reg
    import prc_pkg::*;
#(
    parameter logic [31:0] RESET_VAL = 32'h0000_0000,
    parameter logic [31:0] WR_MASK = 32'hffff_ffff
)
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic writeEn,
    input wire logic [DATA_W-1:0] writeData,
    input wire logic [BYTE_N-1:0] writeStrb,
    output logic [DATA_W-1:0] value
);

    // one lane per byte so narrow accesses leave the others alone
    // each lane owns its flops, so no variable has two writers
    for (genvar b = 0; b < BYTE_N; b++)
    begin : g_lane
        logic [7:0] laneValue_reg;
        wire [7:0] laneMask = WR_MASK[8*b +: 8];
        wire [7:0] laneNext = writeData[8*b +: 8] & laneMask;
        always_ff @(posedge ref_clk or negedge resetn)
        begin
            if (!resetn)
                laneValue_reg <= RESET_VAL[8*b +: 8];
            else if (writeEn && writeStrb[b])
                laneValue_reg <= laneNext;
        end
        assign value[8*b +: 8] = laneValue_reg;
    end

endmodule : prc_byte_reg

// File: verilog/prc_clock_gate.sv
`timescale 1ns/1ps
module prc_clock_gate
#(
    parameter logic RESET_EN = 1'h0
)
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic enable,
    output logic gatedClk
);

    logic enLow_reg;

    // enable moves only while the clock is low, so no runt pulse
    always_ff @(negedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            enLow_reg <= RESET_EN;
        else
            enLow_reg <= enable;
    end

    assign gatedClk = ref_clk & enLow_reg;

endmodule : prc_clock_gate

// File: verilog/prc_top.sv
// How it works
// - bit 28 of reset register holds the power unit in reset while set
// - bit 11 holds the window watchdog in reset while set
// - bit 8 holds timer 13 in reset while set
// - bit 4 holds timer 5 in reset while set
// - bit 1 holds timer 2 in reset while set
// - all bits change only by software writes, never by hardware
// - reset register comes out of system reset as all zeros
// - clock enable register resets to 0x14, only sleep keeps set
// - byte, halfword and word writes update only addressed bytes
// - bit 22 runs the port f clock while set
// - bits 19, 18, 17 run port c, b, a clocks while set
// - bit 6 runs the checksum unit clock while set
// - bit 4 keeps the flash controller clock running in sleep
// - bit 2 keeps the ram interface clock running in sleep
// - bit 0 runs the dma clock while set
`timescale 1ns/1ps
module prc_top
    import prc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic sleepMode,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [DATA_W-1:0] s_axi_wdata,
    input wire logic [BYTE_N-1:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output prc_reset_req_t resetReq,
    output logic [GATE_N-1:0] gatedClks
);

    ////////////////////////////////////////////////////////////////////////
    // write channel capture

    prc_wr_state_t wrState_reg;
    prc_wr_state_t wrState_next;
    logic awHeld_reg;
    logic wHeld_reg;
    logic [ADDR_W-1:0] wAddr_reg;
    logic [DATA_W-1:0] wData_reg;
    logic [BYTE_N-1:0] wStrb_reg;
    logic [1:0] bResp_reg;

    wire awTake = s_axi_awvalid && s_axi_awready;
    wire wTake = s_axi_wvalid && s_axi_wready;
    wire wrCommit = awHeld_reg && wHeld_reg && (wrState_reg == WR_IDLE);
    wire bDone = s_axi_bvalid && s_axi_bready;

    assign s_axi_awready = !awHeld_reg && (wrState_reg == WR_IDLE);
    assign s_axi_wready = !wHeld_reg && (wrState_reg == WR_IDLE);
    assign s_axi_bvalid = (wrState_reg == WR_RESP);
    assign s_axi_bresp = bResp_reg;

    // address and data may arrive in either order
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            awHeld_reg <= 1'h0;
            wAddr_reg <= '0;
        end
        else if (awTake)
        begin
            awHeld_reg <= 1'h1;
            wAddr_reg <= s_axi_awaddr;
        end
        else if (wrCommit)
            awHeld_reg <= 1'h0;
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wHeld_reg <= 1'h0;
            wData_reg <= '0;
            wStrb_reg <= '0;
        end
        else if (wTake)
        begin
            wHeld_reg <= 1'h1;
            wData_reg <= s_axi_wdata;
            wStrb_reg <= s_axi_wstrb;
        end
        else if (wrCommit)
            wHeld_reg <= 1'h0;
    end

    always_comb
    begin
        wrState_next = wrState_reg;
        case (wrState_reg)
            WR_IDLE:
            begin
                if (wrCommit)
                    wrState_next = WR_RESP;
            end
            WR_RESP:
            begin
                if (bDone)
                    wrState_next = WR_IDLE;
            end
            default:
                wrState_next = WR_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            wrState_reg <= WR_IDLE;
        else
            wrState_reg <= wrState_next;
    end

    ////////////////////////////////////////////////////////////////////////
    // decode

    wire [ADDR_W-1:WORD_LSB] wWord = wAddr_reg[ADDR_W-1:WORD_LSB];
    wire [ADDR_W-1:WORD_LSB] rWord = s_axi_araddr[ADDR_W-1:WORD_LSB];
    wire wrRstSel = (wWord == RST_REG_OFFSET[ADDR_W-1:WORD_LSB]);
    wire wrClkSel = (wWord == CLK_REG_OFFSET[ADDR_W-1:WORD_LSB]);
    wire rdRstSel = (rWord == RST_REG_OFFSET[ADDR_W-1:WORD_LSB]);
    wire rdClkSel = (rWord == CLK_REG_OFFSET[ADDR_W-1:WORD_LSB]);
    wire wrRstEn = wrCommit && wrRstSel;
    wire wrClkEn = wrCommit && wrClkSel;

    // unmapped writes still get a response, only flagged as slave error
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            bResp_reg <= RESP_OKAY;
        else if (wrCommit)
            bResp_reg <= (wrRstSel || wrClkSel) ? RESP_OKAY : RESP_SLVERR;
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    logic [DATA_W-1:0] rstReg;
    logic [DATA_W-1:0] clkReg;

    prc_byte_reg #(
        .RESET_VAL(RST_REG_RESET),
        .WR_MASK(RST_REG_MASK)
    ) u_rst_reg (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .writeEn(wrRstEn),
        .writeData(wData_reg),
        .writeStrb(wStrb_reg),
        .value(rstReg)
    );

    prc_byte_reg #(
        .RESET_VAL(CLK_REG_RESET),
        .WR_MASK(CLK_REG_MASK)
    ) u_clk_reg (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .writeEn(wrClkEn),
        .writeData(wData_reg),
        .writeStrb(wStrb_reg),
        .value(clkReg)
    );

    ////////////////////////////////////////////////////////////////////////
    // read channel

    logic rValid_reg;
    logic [DATA_W-1:0] rData_reg;
    logic [1:0] rResp_reg;

    wire arTake = s_axi_arvalid && s_axi_arready;
    wire rdHit = rdRstSel || rdClkSel;
    wire [DATA_W-1:0] rdMux = rdRstSel ? rstReg :
                              rdClkSel ? clkReg : '0;

    assign s_axi_arready = !rValid_reg;
    assign s_axi_rvalid = rValid_reg;
    assign s_axi_rdata = rData_reg;
    assign s_axi_rresp = rResp_reg;

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rValid_reg <= 1'h0;
            rData_reg <= '0;
            rResp_reg <= RESP_OKAY;
        end
        else if (arTake)
        begin
            rValid_reg <= 1'h1;
            rData_reg <= rdMux;
            rResp_reg <= rdHit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rready)
            rValid_reg <= 1'h0;
    end

    ////////////////////////////////////////////////////////////////////////
    // reset requests, straight from the register flops

    assign resetReq.powerUnit = rstReg[BIT_POWER_UNIT];
    assign resetReq.secondI2c = rstReg[BIT_SECOND_I2C];
    assign resetReq.firstI2c = rstReg[BIT_FIRST_I2C];
    assign resetReq.secondSerialPort = rstReg[BIT_SECOND_SERIAL];
    assign resetReq.secondSpi = rstReg[BIT_SECOND_SPI];
    assign resetReq.windowWatchdog = rstReg[BIT_WATCHDOG];
    assign resetReq.timer13 = rstReg[BIT_TIMER_13];
    assign resetReq.timer5 = rstReg[BIT_TIMER_5];
    assign resetReq.timer2 = rstReg[BIT_TIMER_2];

    ////////////////////////////////////////////////////////////////////////
    // clock gates

    logic [GATE_N-1:0] gateEnable;

    assign gateEnable[GATE_PORT_A] = clkReg[BIT_PORT_A];
    assign gateEnable[GATE_PORT_B] = clkReg[BIT_PORT_B];
    assign gateEnable[GATE_PORT_C] = clkReg[BIT_PORT_C];
    assign gateEnable[GATE_PORT_F] = clkReg[BIT_PORT_F];
    assign gateEnable[GATE_CHECKSUM] = clkReg[BIT_CHECKSUM];
    assign gateEnable[GATE_DMA] = clkReg[BIT_DMA];
    // sleep only removes clocks whose keep bit is clear
    assign gateEnable[GATE_FLASH] = !sleepMode || clkReg[BIT_FLASH_KEEP];
    assign gateEnable[GATE_RAM] = !sleepMode || clkReg[BIT_RAM_KEEP];

    for (genvar g = 0; g < GATE_N; g++)
    begin : g_gate
        prc_clock_gate #(
            .RESET_EN(GATE_RESET[g])
        ) u_gate (
            .ref_clk(ref_clk),
            .resetn(resetn),
            .enable(gateEnable[g]),
            .gatedClk(gatedClks[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    logic afterReset_reg;

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            afterReset_reg <= 1'h0;
        else
            afterReset_reg <= 1'h1;
    end

    chk_reset_values: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        !afterReset_reg |-> (rstReg == RST_REG_RESET) &&
                            (clkReg == CLK_REG_RESET) &&
                            (resetReq == '0))
        else $error("registers not at reset value after reset");

    chk_clk_default: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        !afterReset_reg |-> clkReg[BIT_FLASH_KEEP] && clkReg[BIT_RAM_KEEP] &&
                            !clkReg[BIT_DMA] && !clkReg[BIT_PORT_A])
        else $error("clock enable reset pattern wrong");

    chk_no_self_change: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        !wrCommit |=> $stable(rstReg) && $stable(clkReg))
        else $error("register changed without a write");

    chk_power_unit_write: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        wrRstEn && wStrb_reg[3] |=>
            resetReq.powerUnit == $past(wData_reg[BIT_POWER_UNIT]))
        else $error("power unit reset does not follow write");

    chk_periph_write: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        wrRstEn && (wStrb_reg == 4'hf) |=>
            {resetReq.secondI2c, resetReq.firstI2c,
             resetReq.secondSerialPort, resetReq.secondSpi} ==
            {$past(wData_reg[BIT_SECOND_I2C]), $past(wData_reg[BIT_FIRST_I2C]),
             $past(wData_reg[BIT_SECOND_SERIAL]),
             $past(wData_reg[BIT_SECOND_SPI])})
        else $error("peripheral resets do not follow write");

    chk_watchdog_write: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        wrRstEn && wStrb_reg[1] |=>
            resetReq.windowWatchdog == $past(wData_reg[BIT_WATCHDOG]) &&
            resetReq.timer13 == $past(wData_reg[BIT_TIMER_13]))
        else $error("watchdog or timer 13 reset wrong");

    chk_timer_low_write: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        wrRstEn && wStrb_reg[0] |=>
            resetReq.timer5 == $past(wData_reg[BIT_TIMER_5]) &&
            resetReq.timer2 == $past(wData_reg[BIT_TIMER_2]))
        else $error("timer 5 or timer 2 reset wrong");

    chk_lane_untouched: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        wrClkEn && !wStrb_reg[2] |=> $stable(clkReg[23:16]))
        else $error("unaddressed byte lane changed");

    chk_gate_enables: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        wrClkEn && wStrb_reg[2] && wStrb_reg[0] |=>
            gateEnable[GATE_PORT_F] == $past(wData_reg[BIT_PORT_F]) &&
            gateEnable[GATE_PORT_A] == $past(wData_reg[BIT_PORT_A]) &&
            gateEnable[GATE_CHECKSUM] == $past(wData_reg[BIT_CHECKSUM]) &&
            gateEnable[GATE_DMA] == $past(wData_reg[BIT_DMA]))
        else $error("gate enable does not follow write");

    chk_sleep_keep: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        sleepMode |-> gateEnable[GATE_FLASH] == clkReg[BIT_FLASH_KEEP] &&
                      gateEnable[GATE_RAM] == clkReg[BIT_RAM_KEEP])
        else $error("sleep keep gating wrong");

    chk_write_answer: assert property (
        @(posedge ref_clk) disable iff (!resetn)
        wrCommit |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
        else $error("write response not raised after commit");

    cov_reset_write: cover property (
        @(posedge ref_clk) disable iff (!resetn)
        wrRstEn ##1 resetReq.powerUnit);

    cov_clock_read: cover property (
        @(posedge ref_clk) disable iff (!resetn)
        arTake && rdClkSel ##1 s_axi_rvalid);

    cov_unmapped_write: cover property (
        @(posedge ref_clk) disable iff (!resetn)
        wrCommit && !wrRstSel && !wrClkSel);

    cov_sleep_flash_off: cover property (
        @(posedge ref_clk) disable iff (!resetn)
        sleepMode && !gateEnable[GATE_FLASH]);

endmodule : prc_top
